// ### hw/tcs_top.sv
// serial time-code sync block: receiver, transmitter, timer, sync pins, apb registers
//
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
module tcs_top
  import tcs_pkg::*;
(
  input wire logic sys_clk_i, // reference clock
  input wire logic srst_i, // sync reset, high
  input wire logic psel_i, // apb select
  input wire logic penable_i, // apb enable
  input wire logic pwrite_i, // apb write
  input wire logic [7:0] paddr_i, // apb byte address
  input wire logic [31:0] pwdata_i, // apb write data
  output logic [31:0] prdata_o, // apb read data
  output logic pready_o, // apb ready
  output logic pslverr_o, // apb error
  input wire logic pll_clk_i, // low-jitter pll clock, sampled
  input wire logic bit_clk_i, // bit clock in
  output logic bit_clk_o, // bit clock out
  output logic bit_clk_oe_n_o, // low while driving
  input wire logic hb_i, // heartbeat in
  output logic hb_o, // heartbeat out
  output logic hb_oe_n_o, // low while driving
  input wire logic code_i, // time code in
  output logic code_o, // time code out
  output logic code_oe_n_o, // low while driving
  input wire logic [1:0] sync_i, // ext sync pins in
  output logic [1:0] sync_o, // ext sync pins out
  output logic [1:0] sync_oe_n_o, // low while driving
  output logic irq_o // interrupt, level high
);
  import tcs_pkg::*;

  logic [31:0] cfg_r, hb_ctrl_r, sync_ctrl_r, sync_intv_r, drift_r;
  logic [89:0] tx_mem_r;
  logic [97:0] rx_sh_r;
  logic [97:0] rx_reg_r;
  logic chk_err_r;
  logic [31:0] timer_r, hb_cap_r, rx_free_r;
  logic [31:0] cap_r [2];
  logic [IRQ_BITS-1:0] irq_stat_r, irq_mask_r, irq_set;
  logic wr_en, rd_en;
  logic drift_load;

  // apb: single-cycle answer, ready pulses in access phase
  assign wr_en = psel_i && penable_i && pwrite_i && pready_o;
  assign rd_en = psel_i && penable_i && !pwrite_i && pready_o;
  always_ff @(posedge sys_clk_i)
    if (srst_i)
      pready_o <= 1'b0;
    else
      pready_o <= psel_i && !penable_i;

  // two-flop synchronisers for every pin and the pll clock
  logic [6:0] in_s1_r, in_s2_r, in_s3_r;
  always_ff @(posedge sys_clk_i)
    if (srst_i)
    begin
      in_s1_r <= 7'h00;
      in_s2_r <= 7'h00;
      in_s3_r <= 7'h00;
    end
    else
    begin
      in_s1_r <= {pll_clk_i, sync_i, code_i, hb_i, bit_clk_i, 1'b0};
      in_s2_r <= in_s1_r;
      in_s3_r <= in_s2_r;
    end
  wire bclk_rise = in_s2_r[1] && !in_s3_r[1];
  wire hb_rise = in_s2_r[2] && !in_s3_r[2];
  wire code_s = in_s2_r[3];
  wire [1:0] sync_rise = in_s2_r[5:4] & ~in_s3_r[5:4];
  wire pll_rise = in_s2_r[6] && !in_s3_r[6];

  wire en = cfg_r[CFG_ENABLE_BIT];
  wire tx_mode = cfg_r[CFG_TX_MODE_BIT];

  // free-running timer with drift added once per write
  always_ff @(posedge sys_clk_i)
    if (srst_i)
      timer_r <= 32'h0000_0000;
    else if (drift_load)
      timer_r <= timer_r + 32'h0000_0001 + drift_r;
    else
      timer_r <= timer_r + 32'h0000_0001;

  // crc8 step, msb-first
  function automatic logic [7:0] crc_step(input logic [7:0] c, input logic b);
    logic fb;
    fb = c[7] ^ b;
    crc_step = {c[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
  endfunction : crc_step

  // receiver: frame opens on heartbeat rise, start bit, then 97 bits
  typedef enum {TCS_RX_IDLE, TCS_RX_WAIT_START, TCS_RX_SHIFT} tcs_rx_t;
  tcs_rx_t rx_st_r;
  logic [6:0] rx_cnt_r;
  logic [7:0] rx_crc_r;
  logic rx_done, rx_bad;
  always_ff @(posedge sys_clk_i)
    if (srst_i)
    begin
      rx_st_r <= TCS_RX_IDLE;
      rx_cnt_r <= 7'h00;
      rx_crc_r <= 8'h00;
      rx_sh_r <= '0;
      hb_cap_r <= 32'h0000_0000;
    end
    else if (!en || tx_mode)
      rx_st_r <= TCS_RX_IDLE;
    else if (hb_rise)
    begin
      hb_cap_r <= timer_r;
      rx_st_r <= TCS_RX_WAIT_START;
    end
    else if (bclk_rise)
      case (rx_st_r)
        TCS_RX_WAIT_START:
          if (code_s)
          begin
            rx_sh_r <= {97'h0, 1'b1};
            rx_cnt_r <= 7'h01;
            rx_crc_r <= 8'h00;
            rx_st_r <= TCS_RX_SHIFT;
          end
        TCS_RX_SHIFT:
        begin
          rx_sh_r <= {rx_sh_r[96:0], code_s};
          if (rx_cnt_r < 7'(CRC_FIRST))
            rx_crc_r <= crc_step(rx_crc_r, code_s);
          rx_cnt_r <= rx_cnt_r + 7'h01;
          if (rx_cnt_r == 7'(CODE_BITS - 1))
            rx_st_r <= TCS_RX_IDLE;
        end
        default:
          rx_st_r <= rx_st_r;
      endcase
  assign rx_done = bclk_rise && !hb_rise && en && !tx_mode && rx_st_r == TCS_RX_SHIFT
    && rx_cnt_r == 7'(CODE_BITS - 1);
  assign rx_bad = rx_crc_r != {rx_sh_r[6:0], code_s};

  // latch completed code together with its heartbeat timer
  always_ff @(posedge sys_clk_i)
    if (srst_i)
    begin
      rx_reg_r <= '0;
      chk_err_r <= 1'b0;
      rx_free_r <= 32'h0000_0000;
    end
    else if (rx_done)
    begin
      rx_reg_r <= {rx_sh_r[96:0], code_s};
      chk_err_r <= rx_bad;
      rx_free_r <= hb_cap_r;
    end

  // transmit bit clock: divider on reference, or pll edges
  logic [7:0] div_cnt_r;
  logic bclk_r, tick_fall;
  wire [7:0] div_max = cfg_r[CFG_DIV_LSB +: 8];
  wire src_tick = cfg_r[CFG_PLL_SEL_BIT] ? pll_rise : 1'b1;
  always_ff @(posedge sys_clk_i)
    if (srst_i || !en || !tx_mode)
    begin
      div_cnt_r <= 8'h00;
      bclk_r <= 1'b0;
    end
    else if (src_tick)
    begin
      if (div_cnt_r >= div_max)
      begin
        div_cnt_r <= 8'h00;
        bclk_r <= !bclk_r;
      end
      else
        div_cnt_r <= div_cnt_r + 8'h01;
    end
  assign tick_fall = src_tick && div_cnt_r >= div_max && bclk_r;

  // transmitter heartbeat counted in bit clock periods
  logic [31:0] hb_cnt_r;
  logic hb_r, hb_start;
  always_ff @(posedge sys_clk_i)
    if (srst_i || !en || !tx_mode)
    begin
      hb_cnt_r <= 32'h0000_0000;
      hb_r <= 1'b0;
    end
    else if (tick_fall)
    begin
      if (hb_cnt_r >= hb_ctrl_r)
      begin
        hb_cnt_r <= 32'h0000_0000;
        hb_r <= !hb_r;
      end
      else
        hb_cnt_r <= hb_cnt_r + 32'h0000_0001;
    end
  assign hb_start = tick_fall && hb_cnt_r >= hb_ctrl_r && !hb_r;

  // transmitter shifter: code loads at heartbeat rise, crc follows accuracy
  logic [97:0] tx_sh_r;
  logic [6:0] tx_cnt_r;
  logic [7:0] tx_crc_r;
  logic tx_busy_r, code_r, tx_done;
  wire [89:0] tx_frame = {1'b1, tx_mem_r[88:0]}; // start bit forced to one
  always_ff @(posedge sys_clk_i)
    if (srst_i || !en || !tx_mode)
    begin
      tx_sh_r <= '0;
      tx_cnt_r <= 7'h00;
      tx_crc_r <= 8'h00;
      tx_busy_r <= 1'b0;
      code_r <= 1'b0;
    end
    else if (hb_start)
    begin
      code_r <= 1'b1;
      tx_sh_r <= {tx_frame[88:0], 9'h000};
      tx_cnt_r <= 7'h01;
      tx_crc_r <= 8'h00;
      tx_busy_r <= 1'b1;
    end
    else if (tick_fall && tx_busy_r)
    begin
      if (tx_cnt_r < 7'(CRC_FIRST))
      begin
        code_r <= tx_sh_r[97];
        tx_crc_r <= crc_step(tx_crc_r, tx_sh_r[97]);
        tx_sh_r <= {tx_sh_r[96:0], 1'b0};
      end
      else
      begin
        code_r <= tx_crc_r[7];
        tx_crc_r <= {tx_crc_r[6:0], 1'b0};
      end
      tx_cnt_r <= tx_cnt_r + 7'h01;
      if (tx_cnt_r == 7'(CODE_BITS))
      begin
        tx_busy_r <= 1'b0;
        code_r <= 1'b0;
      end
    end
  assign tx_done = tick_fall && tx_busy_r && !hb_start && tx_cnt_r == 7'(CODE_BITS);

  // link pin drivers; receiver mode leaves all three undriven
  always_ff @(posedge sys_clk_i)
    if (srst_i)
    begin
      bit_clk_o <= 1'b0;
      hb_o <= 1'b0;
      code_o <= 1'b0;
      bit_clk_oe_n_o <= 1'b1;
      hb_oe_n_o <= 1'b1;
      code_oe_n_o <= 1'b1;
    end
    else
    begin
      bit_clk_o <= bclk_r;
      hb_o <= hb_r;
      code_o <= code_r;
      bit_clk_oe_n_o <= !(en && tx_mode);
      hb_oe_n_o <= !(en && tx_mode);
      code_oe_n_o <= !(en && tx_mode);
    end

  // external sync pins: bit0 of each pair = output mode, one interval for both
  logic [31:0] sync_cnt_r [2];
  logic [1:0] cap_ev;
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_sync
      wire out_mode = sync_ctrl_r[2*g];
      assign cap_ev[g] = !out_mode && sync_ctrl_r[2*g+1] && sync_rise[g];
      always_ff @(posedge sys_clk_i)
        if (srst_i)
        begin
          sync_cnt_r[g] <= 32'h0000_0000;
          sync_o[g] <= 1'b0;
          sync_oe_n_o[g] <= 1'b1;
          cap_r[g] <= 32'h0000_0000;
        end
        else
        begin
          sync_oe_n_o[g] <= !out_mode;
          if (cap_ev[g])
            cap_r[g] <= timer_r;
          if (!out_mode)
            sync_cnt_r[g] <= 32'h0000_0000;
          else if (sync_cnt_r[g] >= sync_intv_r)
          begin
            sync_cnt_r[g] <= 32'h0000_0000;
            sync_o[g] <= !sync_o[g];
          end
          else
            sync_cnt_r[g] <= sync_cnt_r[g] + 32'h0000_0001;
        end
    end
  endgenerate

  // sticky interrupt status, set wins over write-one clear
  assign irq_set = {tx_done, cap_ev[1], cap_ev[0], rx_done && rx_bad, rx_done};
  always_ff @(posedge sys_clk_i)
    if (srst_i)
      irq_stat_r <= '0;
    else if (wr_en && paddr_i == REG_IRQ_STAT)
      irq_stat_r <= (irq_stat_r & ~pwdata_i[IRQ_BITS-1:0]) | irq_set;
    else
      irq_stat_r <= irq_stat_r | irq_set;
  always_ff @(posedge sys_clk_i)
    if (srst_i)
      irq_o <= 1'b0;
    else
      irq_o <= |(irq_stat_r & irq_mask_r);

  // software-written registers
  always_ff @(posedge sys_clk_i)
    if (srst_i)
    begin
      cfg_r <= CFG_RESET;
      hb_ctrl_r <= HB_RESET;
      sync_ctrl_r <= 32'h0000_0000;
      sync_intv_r <= SYNC_INTV_RESET;
      drift_r <= 32'h0000_0000;
      drift_load <= 1'b0;
      tx_mem_r <= '0;
      irq_mask_r <= '0;
    end
    else
    begin
      drift_load <= wr_en && paddr_i == REG_DRIFT;
      if (wr_en)
        case (paddr_i)
          REG_CONFIG: cfg_r <= pwdata_i;
          REG_HB_CTRL: hb_ctrl_r <= pwdata_i;
          REG_SYNC_CTRL: sync_ctrl_r <= pwdata_i;
          REG_SYNC_INTV: sync_intv_r <= pwdata_i;
          REG_DRIFT: drift_r <= pwdata_i;
          REG_TX_TIME0: tx_mem_r[89:58] <= pwdata_i;
          REG_TX_TIME1: tx_mem_r[57:26] <= pwdata_i;
          REG_TX_TIME2: tx_mem_r[25:0] <= pwdata_i[25:0];
          REG_IRQ_MASK: irq_mask_r <= pwdata_i[IRQ_BITS-1:0];
          default: cfg_r <= cfg_r;
        endcase
    end

  // read mux, unmapped reads zero with pslverr
  always_ff @(posedge sys_clk_i)
    if (srst_i)
    begin
      prdata_o <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end
    else
    begin
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
      if (psel_i && !penable_i && !pwrite_i)
        case (paddr_i)
          REG_CONFIG: prdata_o <= cfg_r;
          REG_HB_CTRL: prdata_o <= hb_ctrl_r;
          REG_RX_TIME0: prdata_o <= rx_reg_r[97:66];
          REG_RX_TIME1: prdata_o <= rx_reg_r[65:34];
          REG_RX_TIME2: prdata_o <= {chk_err_r, rx_reg_r[30:0]};
          REG_RX_FREE: prdata_o <= rx_free_r;
          REG_TX_TIME0: prdata_o <= tx_mem_r[89:58];
          REG_TX_TIME1: prdata_o <= tx_mem_r[57:26];
          REG_TX_TIME2: prdata_o <= {6'h00, tx_mem_r[25:0]};
          REG_TIMER: prdata_o <= timer_r;
          REG_DRIFT: prdata_o <= drift_r;
          REG_SYNC_CTRL: prdata_o <= sync_ctrl_r;
          REG_SYNC_INTV: prdata_o <= sync_intv_r;
          REG_CAP1: prdata_o <= cap_r[0];
          REG_CAP2: prdata_o <= cap_r[1];
          REG_IRQ_STAT: prdata_o <= {27'h0, irq_stat_r};
          REG_IRQ_MASK: prdata_o <= {27'h0, irq_mask_r};
          default: pslverr_o <= 1'b1;
        endcase
    end
endmodule : tcs_top
`default_nettype wire

// ### inc/tcs_pkg.sv
// constants for the serial time-code synchronization block
package tcs_pkg;
  // register byte offsets
  localparam logic [7:0] REG_CONFIG = 8'h00;
  localparam logic [7:0] REG_HB_CTRL = 8'h04;
  localparam logic [7:0] REG_RX_TIME0 = 8'h08;
  localparam logic [7:0] REG_RX_TIME1 = 8'h0c;
  localparam logic [7:0] REG_RX_TIME2 = 8'h10;
  localparam logic [7:0] REG_RX_FREE = 8'h14;
  localparam logic [7:0] REG_TX_TIME0 = 8'h18;
  localparam logic [7:0] REG_TX_TIME1 = 8'h1c;
  localparam logic [7:0] REG_TX_TIME2 = 8'h20;
  localparam logic [7:0] REG_TIMER = 8'h24;
  localparam logic [7:0] REG_DRIFT = 8'h28;
  localparam logic [7:0] REG_SYNC_CTRL = 8'h2c;
  localparam logic [7:0] REG_SYNC_INTV = 8'h30;
  localparam logic [7:0] REG_CAP1 = 8'h34;
  localparam logic [7:0] REG_CAP2 = 8'h38;
  localparam logic [7:0] REG_IRQ_STAT = 8'h3c;
  localparam logic [7:0] REG_IRQ_MASK = 8'h40;
  // config fields
  localparam int CFG_ENABLE_BIT = 0;
  localparam int CFG_TX_MODE_BIT = 1;
  localparam int CFG_PLL_SEL_BIT = 2;
  localparam int CFG_DIV_LSB = 8;
  localparam logic [31:0] CFG_RESET = 32'h0000_0400;
  // time code layout: 1+1+16+32+2+30+8 = 90 bits then 8 crc bits
  localparam int CODE_BITS = 98;
  localparam int CRC_FIRST = 90;
  localparam int CHK_ERR_BIT = 31;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [31:0] HB_RESET = 32'h0000_1000;
  localparam logic [31:0] SYNC_INTV_RESET = 32'h0000_1000;
  // interrupt status bits
  localparam int IRQ_RX_DONE = 0;
  localparam int IRQ_CRC_ERR = 1;
  localparam int IRQ_CAP1 = 2;
  localparam int IRQ_CAP2 = 3;
  localparam int IRQ_TX_DONE = 4;
  localparam int IRQ_BITS = 5;
endpackage : tcs_pkg

// ### verification/tcs_far.sv
// far-end time-code source driving the receiver side
`timescale 1ns/10ps
`default_nettype none
module tcs_far
(
  output var logic bit_clk_o, // link bit clock
  output var logic hb_o, // heartbeat
  output var logic code_o // time code
);
  // clock stands still between frames
  initial
  begin
    bit_clk_o = 1'b0;
    hb_o = 1'b0;
    code_o = 1'b1;
  end
  // one whole code per heartbeat, msb first, data moves on clock fall
  task automatic send(input logic [97:0] frame);
    #7 hb_o = 1'b1;
    #150;
    for (int i = 97; i >= 0; i--)
    begin
      code_o = frame[i];
      #100 bit_clk_o = 1'b1;
      #100 bit_clk_o = 1'b0;
    end
    code_o = ~frame[0];
    #100 hb_o = 1'b0;
  endtask : send
endmodule : tcs_far
`default_nettype wire

// ### verification/tcs_chk.sv
// port checker for the serial time-code block
`timescale 1ns/10ps
`default_nettype none
module tcs_chk
  import tcs_pkg::*;
(
  input wire logic sys_clk_i, // clock
  input wire logic srst_i, // reset
  input wire logic psel_i, // apb select
  input wire logic penable_i, // apb enable
  input wire logic pwrite_i, // apb write
  input wire logic [7:0] paddr_i, // apb address
  input wire logic [31:0] pwdata_i, // apb write data
  input wire logic [31:0] prdata_o, // apb read data
  input wire logic pready_o, // apb ready
  input wire logic pslverr_o, // apb error
  input wire logic bit_clk_o, // bit clock out
  input wire logic bit_clk_oe_n_o, // bit clock drive
  input wire logic hb_o, // heartbeat out
  input wire logic hb_oe_n_o, // heartbeat drive
  input wire logic code_o, // code out
  input wire logic code_oe_n_o // code drive
);
  logic [31:0] cfg_r;
  logic [8:0] hi_r;
  logic tx_on;
  default clocking @(posedge sys_clk_i);
  endclocking
  default disable iff (srst_i);
  // config shadow, taken at the completing apb edge
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
      cfg_r <= CFG_RESET;
    else if (psel_i && penable_i && pready_o && pwrite_i && paddr_i == REG_CONFIG)
      cfg_r <= pwdata_i;
  end
  // high-phase length of the outgoing bit clock
  always_ff @(posedge sys_clk_i)
  begin
    hi_r <= bit_clk_o ? hi_r + 9'd1 : 9'd0;
  end
  assign tx_on = cfg_r[CFG_ENABLE_BIT] && cfg_r[CFG_TX_MODE_BIT];
  property p_zero_wait;
    psel_i && !penable_i ##1 psel_i && penable_i |-> pready_o;
  endproperty
  a_zero_wait: assert property (p_zero_wait)
    else $error("ready missing in access");
  property p_ready_acc;
    pready_o |-> psel_i && penable_i;
  endproperty
  a_ready_acc: assert property (p_ready_acc)
    else $error("ready outside access");
  property p_data_idle;
    !pready_o |-> prdata_o == 32'h0;
  endproperty
  a_data_idle: assert property (p_data_idle)
    else $error("read data outside ready");
  property p_err_read;
    pslverr_o |-> pready_o && !pwrite_i;
  endproperty
  a_err_read: assert property (p_err_read)
    else $error("error not on a read");
  property p_oe_on;
    tx_on [*3] |-> !bit_clk_oe_n_o && !hb_oe_n_o && !code_oe_n_o;
  endproperty
  a_oe_on: assert property (p_oe_on)
    else $error("link not driven in tx");
  property p_oe_off;
    !tx_on [*3] |-> bit_clk_oe_n_o && hb_oe_n_o && code_oe_n_o;
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("link driven in rx");
  property p_code_fall;
    !code_oe_n_o && $changed(code_o) |-> !bit_clk_o;
  endproperty
  a_code_fall: assert property (p_code_fall)
    else $error("code moved with clock high");
  property p_hb_fall;
    $rose(hb_o) && !hb_oe_n_o |-> !bit_clk_o;
  endproperty
  a_hb_fall: assert property (p_hb_fall)
    else $error("heartbeat rose with clock high");
  property p_start;
    $rose(hb_o) && !hb_oe_n_o |-> ##[0:2] code_o;
  endproperty
  a_start: assert property (p_start)
    else $error("start bit missing");
  property p_half;
    $fell(bit_clk_o) && !bit_clk_oe_n_o && !cfg_r[CFG_PLL_SEL_BIT]
      |-> hi_r == {1'b0, cfg_r[CFG_DIV_LSB +: 8]} + 9'd1;
  endproperty
  a_half: assert property (p_half)
    else $error("bit clock half period wrong");
endmodule : tcs_chk
bind tcs_top tcs_chk u_chk (.sys_clk_i, .srst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
  .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .bit_clk_o, .bit_clk_oe_n_o, .hb_o,
  .hb_oe_n_o, .code_o, .code_oe_n_o);
`default_nettype wire

// ### verification/testbench.sv
// self-checking bench for the serial time-code block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import tcs_pkg::*;
  logic clk, srst, psel, penable, pwrite, pready, pslverr, pll, irq, s0;
  logic f_bclk, f_hb, f_code, bclk_o, bclk_oe_n, hb_o, hb_oe_n, code_o, code_oe_n;
  logic bclk_w, hb_w, code_w, hb_q, bc_q;
  logic [1:0] sync_drv, sync_o, sync_oe_n, sync_w;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, seed, r1, r2, r3;
  logic [88:0] body;
  logic [89:0] t90;
  logic [97:0] frame, tx_sh;
  logic [32:0] q_rd[$];
  logic [97:0] q_tx[$];
  int n_errors, check_count, k, n, tx_n;
  logic [31:0] cyc, hb_at;
  logic f_hb_q;
  // wire level from whoever drives it
  assign bclk_w = bclk_oe_n ? f_bclk : bclk_o;
  assign hb_w = hb_oe_n ? f_hb : hb_o;
  assign code_w = code_oe_n ? f_code : code_o;
  assign sync_w[0] = sync_oe_n[0] ? sync_drv[0] : sync_o[0];
  assign sync_w[1] = sync_oe_n[1] ? sync_drv[1] : sync_o[1];
  tcs_top u_dut (.sys_clk_i(clk), .srst_i(srst), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .pll_clk_i(pll), .bit_clk_i(bclk_w),
    .bit_clk_o(bclk_o), .bit_clk_oe_n_o(bclk_oe_n), .hb_i(hb_w), .hb_o(hb_o),
    .hb_oe_n_o(hb_oe_n), .code_i(code_w), .code_o(code_o), .code_oe_n_o(code_oe_n),
    .sync_i(sync_w), .sync_o(sync_o), .sync_oe_n_o(sync_oe_n), .irq_o(irq));
  tcs_far u_far (.bit_clk_o(f_bclk), .hb_o(f_hb), .code_o(f_code));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [7:0] crc8(input logic [88:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 88; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? CRC_POLY : 8'h00);
    return c;
  endfunction : crc8
  task automatic chk(input string what, input logic [97:0] e, input logic [97:0] g);
    check_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic e);
    int t;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w)
      q_rd.push_back({e, d});
    @(posedge clk);
    penable <= 1'b1;
    t = 0;
    do
    begin
      @(posedge clk);
      t++;
    end
    while (pready !== 1'b1 && t < 20);
    if (pready !== 1'b1)
    begin
      n_errors++;
      $display("Error apb ready expected 1 seen %b", pready);
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic irq_is(input logic e);
    repeat (2) @(posedge clk);
    chk("irq", {97'h0, e}, {97'h0, irq});
  endtask : irq_is
  task automatic give_verdict;
    $display("TB: checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial
  begin
    pll = 1'b0;
    forever #75 pll = ~pll;
  end
  // read results compared as they appear
  always @(posedge clk)
  begin
    if (psel && penable && pready && !pwrite && q_rd.size() > 0)
      chk("apb read", {65'h0, q_rd.pop_front()}, {65'h0, pslverr, prdata});
  end
  // outgoing codes gathered on bit clock rises after a heartbeat rise
  always @(posedge clk)
  begin
    hb_q <= hb_o;
    bc_q <= bclk_o;
    if (hb_o && !hb_q && !hb_oe_n)
      tx_n <= 98;
    else if (bclk_o && !bc_q && tx_n > 0)
    begin
      tx_sh <= {tx_sh[96:0], code_o};
      tx_n <= tx_n - 1;
      if (tx_n == 1 && q_tx.size() > 0)
        chk("tx code", q_tx.pop_front(), {tx_sh[96:0], code_o});
    end
  end
  // cycles since reset, equal to the timer until a drift is written
  always @(posedge clk)
  begin
    cyc <= srst ? 32'h0000_0000 : cyc + 32'h0000_0001;
    f_hb_q <= f_hb;
    if (f_hb && !f_hb_q)
      hb_at <= cyc;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    give_verdict();
  end
  initial
  begin
    {srst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
    sync_drv = 2'b00;
    seed = 32'h0000_0018;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    // reset values, then unmapped read and write
    apb(1'b0, REG_CONFIG, CFG_RESET, 1'b0);
    apb(1'b0, REG_HB_CTRL, HB_RESET, 1'b0);
    apb(1'b0, REG_SYNC_INTV, SYNC_INTV_RESET, 1'b0);
    apb(1'b1, 8'h44, 32'hffff_ffff, 1'b0);
    apb(1'b0, 8'h44, 32'h0, 1'b1);
    apb(1'b1, REG_IRQ_MASK, 32'h0000_001f, 1'b0);
    apb(1'b1, REG_CONFIG, CFG_RESET | 32'h1, 1'b0);
    // good code, then one with a corrupted check byte
    for (k = 0; k < 2; k++)
    begin
      seed = lfsr(seed);
      r1 = seed;
      seed = lfsr(seed);
      r2 = seed;
      seed = lfsr(seed);
      r3 = seed;
      body = {r1[0], r1[31:16], r2, 2'b00, r3[29:0], r1[15:8]};
      frame = {1'b1, body, crc8(body) ^ {7'h0, k[0]}};
      u_far.send(frame);
      @(posedge clk);
      for (n = 0; n < 50 && irq !== 1'b1; n++)
        @(posedge clk);
      chk("rx irq", {97'h0, 1'b1}, {97'h0, irq});
      apb(1'b0, REG_RX_TIME0, frame[97:66], 1'b0);
      apb(1'b0, REG_RX_TIME1, frame[65:34], 1'b0);
      apb(1'b0, REG_RX_TIME2, {k[0], frame[30:0]}, 1'b0);
      // heartbeat seen two synchroniser flops late
      apb(1'b0, REG_RX_FREE, hb_at + 32'h0000_0002, 1'b0);
    end
    apb(1'b0, REG_IRQ_STAT, 32'h3, 1'b0);
    apb(1'b1, REG_IRQ_MASK, 32'h0, 1'b0);
    irq_is(1'b0);
    apb(1'b1, REG_IRQ_MASK, 32'h0000_001f, 1'b0);
    irq_is(1'b1);
    apb(1'b1, REG_IRQ_STAT, 32'h3, 1'b0);
    irq_is(1'b0);
    // capture on both sync inputs
    apb(1'b1, REG_SYNC_CTRL, 32'h0000_000a, 1'b0);
    sync_drv <= 2'b11;
    repeat (8) @(posedge clk);
    apb(1'b0, REG_IRQ_STAT, 32'h0000_000c, 1'b0);
    apb(1'b1, REG_IRQ_STAT, 32'h0000_000c, 1'b0);
    // both pins as toggling outputs
    apb(1'b1, REG_SYNC_INTV, 32'h3, 1'b0);
    apb(1'b1, REG_SYNC_CTRL, 32'h5, 1'b0);
    for (k = 0; k < 4; k++)
    begin
      s0 = sync_o[k/2];
      for (n = 0; n < 20 && sync_o[k/2] === s0; n++)
        @(posedge clk);
      if (k[0])
        chk("sync interval", 98'd4, 98'(n));
    end
    // transmitter sends the written code with its own check byte
    seed = lfsr(seed);
    r1 = seed;
    seed = lfsr(seed);
    r2 = seed;
    seed = lfsr(seed);
    r3 = seed;
    apb(1'b1, REG_TX_TIME0, r1, 1'b0);
    apb(1'b1, REG_TX_TIME1, r2, 1'b0);
    apb(1'b1, REG_TX_TIME2, r3, 1'b0);
    t90 = {1'b1, r1[30:0], r2, r3[25:0]};
    q_tx.push_back({t90, crc8(t90[88:0])});
    apb(1'b1, REG_HB_CTRL, 32'd127, 1'b0);
    apb(1'b1, REG_CONFIG, 32'h0000_0103, 1'b0);
    for (n = 0; n < 3000 && q_tx.size() > 0; n++)
      @(posedge clk);
    chk("tx pending", 98'h0, 98'(q_tx.size()));
    apb(1'b0, REG_IRQ_STAT, 32'h0000_0010, 1'b0);
    // same code again, bit clock now taken from the pll edges
    q_tx.push_back({t90, crc8(t90[88:0])});
    apb(1'b1, REG_CONFIG, 32'h0000_0107, 1'b0);
    for (n = 0; n < 8000 && q_tx.size() > 0; n++)
      @(posedge clk);
    chk("pll tx pending", 98'h0, 98'(q_tx.size()));
    // timer follows the cycle count, then jumps once by the drift
    apb(1'b0, REG_TIMER, cyc + 32'h0000_0001, 1'b0);
    apb(1'b1, REG_DRIFT, 32'h0000_1000, 1'b0);
    apb(1'b0, REG_TIMER, cyc + 32'h0000_1001, 1'b0);
    chk("rd pending", 98'h0, 98'(q_rd.size()));
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
